// *** src/sgprot_top.v ***
// sgprot_top.v: supply, thermal, desaturation and overcurrent supervision
// assumes comparator pins asynchronous; config ports steady, clear pulses
// What this block does
// - positive supply undervoltage forces safe state, flag
// - unlatched mode clears positive undervoltage on recovery
// - latched mode holds until recovered and cleared
// - negative supply undervoltage forces safe state, flag
// - unlatched mode clears negative undervoltage on recovery
// - latched negative undervoltage holds until cleared
// - disable code in turn-on level disables undervoltage
// - positive overvoltage latches flag and safe state
// - negative overvoltage latches flag and safe state
// - flyback input undervoltage stops flyback, auto clears
// - logic supply undervoltage enabled unless disable set
// - logic undervoltage always stops flyback controller
// - thermal warning flag follows comparator, no safe
// - thermal shutdown forces safe state, auto clears
// - switch off: monitor pin discharged, source off
// - after turn-on wait blanking, then charge capacitor
// - saturation trip: predrive high, flag 200 ns later
// - saturation comparator ignored when off or tripped
// - short saturation excursions filtered out
// - saturation protection has its own enable
// - overcurrent trip: predrive high, flag 200 ns later
// - overcurrent protection has its own enable
`timescale 1ns/1ps
`include "sgprot_regs.vh"

module sgprot_top (
   input wire clk_i,
   input wire sys_rst_i,
   // comparator results, asynchronous
   input wire pos_uv_cmp_i,
   input wire neg_uv_cmp_i,
   input wire pos_ov_cmp_i,
   input wire neg_ov_cmp_i,
   input wire flyback_uv_cmp_i,
   input wire logic_uv_cmp_i,
   input wire therm_warn_cmp_i,
   input wire therm_sdn_cmp_i,
   input wire saturation_monitor_pin_cmp_i,
   input wire sense_cmp_i,
   // configuration
   input wire undervolt_latch_select_i,
   input wire [2:0] pos_supply_turnon_level_i,
   input wire [2:0] neg_supply_turnon_level_i,
   input wire logic_supply_uv_disable_i,
   input wire saturation_protect_enable_i,
   input wire shunt_protect_enable_i,
   input wire [1:0] saturation_monitor_pin_filter_sel_i,
   // drive request and flag clears
   input wire drive_on_i,
   input wire clr_pos_uv_i,
   input wire clr_neg_uv_i,
   input wire clr_pos_ov_i,
   input wire clr_neg_ov_i,
   input wire clr_saturation_monitor_pin_i,
   input wire clr_sense_i,
   // outputs
   output reg pchannel_predrive_o,
   output reg nchannel_predrive_o,
   output reg protective_off_state_o,
   output reg flyback_stop_o,
   output reg saturation_monitor_pin_discharge_o,
   output reg saturation_monitor_pin_source_en_o,
   output reg pos_supply_undervolt_flag_o,
   output reg neg_supply_undervolt_flag_o,
   output reg pos_supply_overvolt_flag_o,
   output reg neg_supply_overvolt_flag_o,
   output reg flyback_input_undervolt_flag_o,
   output reg logic_supply_undervolt_flag_o,
   output reg thermal_warning_flag_o,
   output reg thermal_shutdown_flag_o,
   output reg saturation_fault_flag_o,
   output reg shunt_overcurrent_flag_o
);

   // ==========================================================
   // two-stage synchronisers
   reg [9:0] meta_r;
   reg [9:0] sync_r;
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         meta_r <= 10'h000;
         sync_r <= 10'h000;
      end else begin
         meta_r <= {sense_cmp_i, saturation_monitor_pin_cmp_i, therm_sdn_cmp_i,
            therm_warn_cmp_i, logic_uv_cmp_i, flyback_uv_cmp_i,
            neg_ov_cmp_i, pos_ov_cmp_i, neg_uv_cmp_i, pos_uv_cmp_i};
         sync_r <= meta_r;
      end
   end
   wire pos_uv = sync_r[0];
   wire neg_uv = sync_r[1];
   wire pos_ov = sync_r[2];
   wire neg_ov = sync_r[3];
   wire fly_uv = sync_r[4];
   wire log_uv = sync_r[5];
   wire t_warn = sync_r[6];
   wire t_sdn = sync_r[7];
   wire saturation_monitor_pin_c = sync_r[8];
   wire sense_c = sync_r[9];

   // ==========================================================
   // undervoltage enables
   wire pos_uv_en = pos_supply_turnon_level_i != `SGPROT_LVL_DISABLE;
   wire neg_uv_en = neg_supply_turnon_level_i != `SGPROT_LVL_DISABLE;
   wire log_uv_en = !logic_supply_uv_disable_i;

   // ==========================================================
   // supply flags; set wins over clear
   reg pos_uv_nxt;
   reg neg_uv_nxt;
   reg pos_ov_nxt;
   reg neg_ov_nxt;
   always @* begin
      pos_uv_nxt = pos_supply_undervolt_flag_o;
      if (!pos_uv_en)
         pos_uv_nxt = 1'b0;
      else if (pos_uv)
         pos_uv_nxt = 1'b1;
      else if (!undervolt_latch_select_i)
         pos_uv_nxt = 1'b0;
      else if (clr_pos_uv_i)
         pos_uv_nxt = 1'b0;
      neg_uv_nxt = neg_supply_undervolt_flag_o;
      if (!neg_uv_en)
         neg_uv_nxt = 1'b0;
      else if (neg_uv)
         neg_uv_nxt = 1'b1;
      else if (!undervolt_latch_select_i)
         neg_uv_nxt = 1'b0;
      else if (clr_neg_uv_i)
         neg_uv_nxt = 1'b0;
      // clear only counts once the supply has recovered
      pos_ov_nxt = pos_ov
         | (pos_supply_overvolt_flag_o & ~clr_pos_ov_i);
      neg_ov_nxt = neg_ov
         | (neg_supply_overvolt_flag_o & ~clr_neg_ov_i);
   end

   // ==========================================================
   // saturation monitor: blanking, filter, trip
   reg on_r;
   wire sw_on = on_r;
   wire blank_done;
   sgprot_delay #(.COUNT(`SGPROT_BLANK_CYC)) u_blank (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .start_i(sw_on),
      .done_o(blank_done)
   );

   reg saturation_monitor_pin_trip_r;
   reg sense_trip_r;
   reg [`SGPROT_CNT_W-1:0] filt_r;
   reg [`SGPROT_CNT_W-1:0] filt_lim;
   always @* begin
      case (saturation_monitor_pin_filter_sel_i)
         2'h0: filt_lim = `SGPROT_FILT_CYC0;
         2'h1: filt_lim = `SGPROT_FILT_CYC1;
         2'h2: filt_lim = `SGPROT_FILT_CYC2;
         default: filt_lim = `SGPROT_FILT_CYC3;
      endcase
   end
   // comparator only looked at while on and not yet tripped
   wire saturation_monitor_pin_watch = sw_on & blank_done & ~saturation_monitor_pin_trip_r
      & saturation_protect_enable_i;
   wire saturation_monitor_pin_hit = saturation_monitor_pin_watch & saturation_monitor_pin_c & (filt_r >= filt_lim);

   always @(posedge clk_i) begin
      if (sys_rst_i || !saturation_monitor_pin_watch || !saturation_monitor_pin_c)
         filt_r <= 8'h00;
      else if (filt_r < filt_lim)
         filt_r <= filt_r + 8'h01;
   end

   wire sense_hit = sw_on & sense_c & ~sense_trip_r
      & shunt_protect_enable_i;

   // trip detection arms delays to output turn-off
   reg saturation_monitor_pin_arm_r;
   reg sense_arm_r;
   reg saturation_monitor_pin_flag_seen_r;
   reg sense_flag_seen_r;
   wire saturation_monitor_pin_off_done;
   wire sense_off_done;
   wire saturation_monitor_pin_flag_done;
   wire sense_flag_done;
   sgprot_delay #(.COUNT(`SGPROT_SATURATION_MONITOR_PIN_DLY_CYC)) u_saturation_monitor_pin_dly (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .start_i(saturation_monitor_pin_arm_r),
      .done_o(saturation_monitor_pin_off_done)
   );
   sgprot_delay #(.COUNT(`SGPROT_SENSE_DLY_CYC)) u_sense_dly (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .start_i(sense_arm_r),
      .done_o(sense_off_done)
   );
   sgprot_delay #(.COUNT(`SGPROT_FLAG_DLY_CYC)) u_saturation_monitor_pin_flag (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .start_i(saturation_monitor_pin_trip_r),
      .done_o(saturation_monitor_pin_flag_done)
   );
   sgprot_delay #(.COUNT(`SGPROT_FLAG_DLY_CYC)) u_sense_flag (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .start_i(sense_trip_r),
      .done_o(sense_flag_done)
   );

   // ==========================================================
   // fault state registers
   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         saturation_monitor_pin_arm_r <= 1'b0;
         sense_arm_r <= 1'b0;
         saturation_monitor_pin_trip_r <= 1'b0;
         sense_trip_r <= 1'b0;
      end else begin
         if (saturation_monitor_pin_hit)
            saturation_monitor_pin_arm_r <= 1'b1;
         else if (saturation_monitor_pin_off_done)
            saturation_monitor_pin_arm_r <= 1'b0;
         if (saturation_monitor_pin_off_done)
            saturation_monitor_pin_trip_r <= 1'b1;
         else if (clr_saturation_monitor_pin_i && saturation_fault_flag_o)
            saturation_monitor_pin_trip_r <= 1'b0;
         if (sense_hit)
            sense_arm_r <= 1'b1;
         else if (sense_off_done)
            sense_arm_r <= 1'b0;
         if (sense_off_done)
            sense_trip_r <= 1'b1;
         else if (clr_sense_i && shunt_overcurrent_flag_o)
            sense_trip_r <= 1'b0;
      end
   end

   // ==========================================================
   // safe state and outputs
   wire safe_nxt = pos_uv_nxt | neg_uv_nxt | pos_ov_nxt | neg_ov_nxt
      | t_sdn | (log_uv & log_uv_en)
      | saturation_monitor_pin_trip_r | saturation_monitor_pin_off_done
      | sense_trip_r | sense_off_done;
   wire on_nxt = drive_on_i & ~safe_nxt;

   always @(posedge clk_i) begin
      if (sys_rst_i) begin
         on_r <= 1'b0;
         pchannel_predrive_o <= 1'b1;
         nchannel_predrive_o <= 1'b1;
         protective_off_state_o <= 1'b1;
         flyback_stop_o <= 1'b1;
         saturation_monitor_pin_discharge_o <= 1'b1;
         saturation_monitor_pin_source_en_o <= 1'b0;
         pos_supply_undervolt_flag_o <= 1'b0;
         neg_supply_undervolt_flag_o <= 1'b0;
         pos_supply_overvolt_flag_o <= 1'b0;
         neg_supply_overvolt_flag_o <= 1'b0;
         flyback_input_undervolt_flag_o <= 1'b0;
         logic_supply_undervolt_flag_o <= 1'b0;
         thermal_warning_flag_o <= 1'b0;
         thermal_shutdown_flag_o <= 1'b0;
         saturation_fault_flag_o <= 1'b0;
         shunt_overcurrent_flag_o <= 1'b0;
         saturation_monitor_pin_flag_seen_r <= 1'b0;
         sense_flag_seen_r <= 1'b0;
      end else begin
         on_r <= on_nxt;
         pchannel_predrive_o <= ~on_nxt;
         nchannel_predrive_o <= ~on_nxt;
         protective_off_state_o <= safe_nxt;
         flyback_stop_o <= fly_uv | log_uv;
         // discharge held while off and during blanking
         saturation_monitor_pin_discharge_o <= ~(on_nxt & blank_done);
         saturation_monitor_pin_source_en_o <= on_nxt & blank_done;
         pos_supply_undervolt_flag_o <= pos_uv_nxt;
         neg_supply_undervolt_flag_o <= neg_uv_nxt;
         pos_supply_overvolt_flag_o <= pos_ov_nxt;
         neg_supply_overvolt_flag_o <= neg_ov_nxt;
         flyback_input_undervolt_flag_o <= fly_uv;
         logic_supply_undervolt_flag_o <= log_uv & log_uv_en;
         thermal_warning_flag_o <= t_warn;
         thermal_shutdown_flag_o <= t_sdn;
         // set on the first expired cycle only, else a clear
         // would be undone while the delay still reads done
         saturation_monitor_pin_flag_seen_r <= saturation_monitor_pin_flag_done;
         sense_flag_seen_r <= sense_flag_done;
         if (saturation_monitor_pin_flag_done && !saturation_monitor_pin_flag_seen_r)
            saturation_fault_flag_o <= 1'b1;
         else if (clr_saturation_monitor_pin_i)
            saturation_fault_flag_o <= 1'b0;
         if (sense_flag_done && !sense_flag_seen_r)
            shunt_overcurrent_flag_o <= 1'b1;
         else if (clr_sense_i)
            shunt_overcurrent_flag_o <= 1'b0;
      end
   end
endmodule // sgprot_top

// *** src/sgprot_regs.vh ***
// sgprot_regs.vh: timing counts and configuration codes for the fault block
// assumes a 100 MHz clock; included by every design file of the block
`ifndef SGPROT_REGS_VH
`define SGPROT_REGS_VH

// ==========================================================
// clock
`define SGPROT_CLK_MHZ 100
`define SGPROT_CLK_NS 10

// ==========================================================
// timing, figure in ns and derived cycles
// cycle counts sized to the delay counter, 10 ns a cycle
`define SGPROT_FLAG_DLY_NS 200
`define SGPROT_FLAG_DLY_CYC 8'h14
`define SGPROT_BLANK_NS 500
`define SGPROT_BLANK_CYC 8'h32
`define SGPROT_SATURATION_MONITOR_PIN_DLY_NS 100
`define SGPROT_SATURATION_MONITOR_PIN_DLY_CYC 8'h0a
`define SGPROT_SENSE_DLY_NS 100
`define SGPROT_SENSE_DLY_CYC 8'h0a

// ==========================================================
// codes and widths
`define SGPROT_CNT_W 8
`define SGPROT_LVL_W 3
`define SGPROT_LVL_DISABLE 3'h7
`define SGPROT_FILT_W 2
`define SGPROT_FILT_CYC0 8'h01
`define SGPROT_FILT_CYC1 8'h19
`define SGPROT_FILT_CYC2 8'h32
`define SGPROT_FILT_CYC3 8'h64

`endif

// *** src/sgprot_delay.v ***
// sgprot_delay.v: counts a held level for a fixed number of cycles
// assumes synchronous inputs on clk_i
`timescale 1ns/1ps
`include "sgprot_regs.vh"

module sgprot_delay #(
   parameter [`SGPROT_CNT_W-1:0] COUNT = 8'h01
) (
   input wire clk_i,
   input wire sys_rst_i,
   input wire start_i,
   output reg done_o
);
   reg [`SGPROT_CNT_W-1:0] cnt_r;

   // ==========================================================
   // counter restarts whenever start drops
   always @(posedge clk_i) begin
      if (sys_rst_i || !start_i) begin
         cnt_r <= 8'h00;
         done_o <= 1'b0;
      end else if (cnt_r < COUNT) begin
         cnt_r <= cnt_r + 8'h01;
         done_o <= (cnt_r + 8'h01) >= COUNT;
      end else begin
         done_o <= 1'b1;
      end
   end
endmodule // sgprot_delay

// *** test/sgprot_sw_model.sv ***
// sgprot_sw_model.sv: power switch and blanking capacitor
// assumes predrive state and source enable from the block
`timescale 1ns/1ps
module sgprot_sw_model (
   input wire clk_i,
   input wire off_i,
   input wire src_en_i,
   input wire overload_i,
   output wire saturation_monitor_pin_cmp_o
);
   // ===
   // capacitor charge
   reg [2:0] chg_r;
   always @(posedge clk_i) begin
      if (off_i || !src_en_i)
         chg_r <= 3'h0;
      else if (chg_r != 3'h4)
         chg_r <= chg_r + 3'h1;
   end
   // low drop clamps the pin, only overload trips
   assign saturation_monitor_pin_cmp_o = overload_i && (chg_r == 3'h4);
endmodule // sgprot_sw_model

// *** test/sgprot_top_chk.sv ***
// sgprot_top_chk.sv: port assertions for the fault block
// assumes bind to sgprot_top; one clock, sync reset
`timescale 1ns/1ps
module sgprot_top_chk (
   input wire clk_i,
   input wire sys_rst_i,
   input wire pos_uv_cmp_i,
   input wire undervolt_latch_select_i,
   input wire [2:0] pos_supply_turnon_level_i,
   input wire saturation_protect_enable_i,
   input wire clr_pos_uv_i,
   input wire clr_pos_ov_i,
   input wire pchannel_predrive_o,
   input wire nchannel_predrive_o,
   input wire protective_off_state_o,
   input wire saturation_monitor_pin_discharge_o,
   input wire saturation_monitor_pin_source_en_o,
   input wire pos_supply_undervolt_flag_o,
   input wire neg_supply_undervolt_flag_o,
   input wire pos_supply_overvolt_flag_o,
   input wire neg_supply_overvolt_flag_o,
   input wire thermal_shutdown_flag_o,
   input wire saturation_fault_flag_o,
   input wire shunt_overcurrent_flag_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // ===
   // cycles the switch has been on
   reg [7:0] on_cnt_r;
   always @(posedge clk_i) begin
      if (sys_rst_i || pchannel_predrive_o)
         on_cnt_r <= 8'h00;
      else if (on_cnt_r != 8'hff)
         on_cnt_r <= on_cnt_r + 8'h01;
   end
   AST_POS_UV_SET: assert property (
      (pos_uv_cmp_i && pos_supply_turnon_level_i != 3'h7)[*4]
      |-> pos_supply_undervolt_flag_o) else $error("uv flag not set");
   AST_POS_UV_AUTO: assert property (
      (!pos_uv_cmp_i && !undervolt_latch_select_i)[*4]
      |-> !pos_supply_undervolt_flag_o) else $error("uv flag stuck");
   AST_POS_UV_HOLD: assert property (
      pos_supply_undervolt_flag_o && undervolt_latch_select_i && !clr_pos_uv_i
      |=> pos_supply_undervolt_flag_o) else $error("uv latch lost");
   AST_OV_HOLD: assert property (
      pos_supply_overvolt_flag_o && !clr_pos_ov_i
      |=> pos_supply_overvolt_flag_o) else $error("ov latch lost");
   AST_SAFE_OR: assert property (
      (pos_supply_undervolt_flag_o || neg_supply_undervolt_flag_o ||
       pos_supply_overvolt_flag_o || neg_supply_overvolt_flag_o ||
       thermal_shutdown_flag_o || saturation_fault_flag_o ||
       shunt_overcurrent_flag_o) |-> protective_off_state_o)
      else $error("flag without safe state");
   AST_OFF_DISCH: assert property (
      (pchannel_predrive_o && nchannel_predrive_o)[*2]
      |-> saturation_monitor_pin_discharge_o && !saturation_monitor_pin_source_en_o) else $error("pin not held");
   AST_BLANK: assert property (
      saturation_monitor_pin_source_en_o |-> on_cnt_r >= 8'h30) else $error("blanking short");
   AST_SAT_ORDER: assert property (
      $rose(saturation_fault_flag_o) |-> pchannel_predrive_o &&
      nchannel_predrive_o && $past(pchannel_predrive_o, 18))
      else $error("sat flag too early");
   AST_SAT_EN: assert property (
      !saturation_protect_enable_i |-> !$rose(saturation_fault_flag_o))
      else $error("sat trip while disabled");
   cover property ($rose(saturation_fault_flag_o));
   cover property ($rose(shunt_overcurrent_flag_o));
   cover property ($fell(pos_supply_overvolt_flag_o));
endmodule // sgprot_top_chk

// *** test/sgprot_top_tb_top.sv ***
// sgprot_top_tb_top.sv: self-checking bench for the fault block
// assumes sgprot_sw_model on the switch side; checker bound below
`timescale 1ns/1ps
module sgprot_top_tb_top;
   // starting low at declaration keeps time zero free of a clock edge
   logic clk_i = 1'b0;
   logic sys_rst_i, lat, ldis, sen, shen, don, ovl;
   logic [1:0] fs;
   logic [2:0] lvp, lvn;
   logic [9:0] c;
   logic [5:0] k;
   wire [9:0] f;
   wire pch, nch, safe, fly, dis, src, dcmp;
   wire [3:0] w = {f[9], f[8], pch, src};
   int err_total, checked, seed, n, i;
   sgprot_top i_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .pos_uv_cmp_i(c[0]), .neg_uv_cmp_i(c[1]), .pos_ov_cmp_i(c[2]),
      .neg_ov_cmp_i(c[3]), .flyback_uv_cmp_i(c[4]), .logic_uv_cmp_i(c[5]),
      .therm_warn_cmp_i(c[6]), .therm_sdn_cmp_i(c[7]),
      .saturation_monitor_pin_cmp_i(dcmp), .sense_cmp_i(c[9]),
      .undervolt_latch_select_i(lat), .pos_supply_turnon_level_i(lvp),
      .neg_supply_turnon_level_i(lvn), .logic_supply_uv_disable_i(ldis),
      .saturation_protect_enable_i(sen), .shunt_protect_enable_i(shen),
      .saturation_monitor_pin_filter_sel_i(fs), .drive_on_i(don),
      .clr_pos_uv_i(k[0]), .clr_neg_uv_i(k[1]), .clr_pos_ov_i(k[2]),
      .clr_neg_ov_i(k[3]), .clr_saturation_monitor_pin_i(k[4]), .clr_sense_i(k[5]),
      .pchannel_predrive_o(pch), .nchannel_predrive_o(nch),
      .protective_off_state_o(safe), .flyback_stop_o(fly),
      .saturation_monitor_pin_discharge_o(dis), .saturation_monitor_pin_source_en_o(src),
      .pos_supply_undervolt_flag_o(f[0]), .neg_supply_undervolt_flag_o(f[1]),
      .pos_supply_overvolt_flag_o(f[2]), .neg_supply_overvolt_flag_o(f[3]),
      .flyback_input_undervolt_flag_o(f[4]),
      .logic_supply_undervolt_flag_o(f[5]), .thermal_warning_flag_o(f[6]),
      .thermal_shutdown_flag_o(f[7]), .saturation_fault_flag_o(f[8]),
      .shunt_overcurrent_flag_o(f[9]));
   sgprot_sw_model i_sw (.clk_i(clk_i), .off_i(pch & nch),
      .src_en_i(src), .overload_i(ovl), .saturation_monitor_pin_cmp_o(dcmp));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // ===
   // helpers
   task cyc(input int m);
      repeat (m) @(negedge clk_i);
   endtask
   task chk(input logic [9:0] g, input logic [9:0] e);
      checked++;
      if (g !== e) begin
         err_total++;
         $display("wrong value at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   task ok(input logic g);
      chk({9'h000, g}, 10'h001);
   endtask
   task final_report;
      if (err_total == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // bounded wait; a hang ends the run
   task upto(input int s);
      n = 0;
      while (n < 400 && w[s] !== 1'b1) begin
         cyc(1);
         n++;
      end
      if (n == 400) begin
         err_total++;
         final_report;
      end
   endtask
   task clr(input int j);
      k[j] = 1'b1;
      cyc(1);
      k = 6'h00;
   endtask
   // expected flags from the latch and safe-state table
   task fault(input int j, input bit en);
      logic [9:0] e;
      bit lt, sf;
      lt = j == 2 || j == 3 || (j < 2 && lat);
      sf = en && (j < 4 || j == 5 || j == 7);
      e = 10'h000;
      e[j] = en;
      c[j] = 1'b1;
      cyc(4 + ($random(seed) & 3));
      chk(f, e);
      chk({8'h00, safe, fly}, {8'h00, sf, j == 4 || j == 5});
      if (lt) begin
         clr(j);
         cyc(1);
         chk(f, e);
      end
      c[j] = 1'b0;
      cyc(4);
      e[j] = en && lt;
      chk(f, e);
      ok(safe === (sf && lt));
      if (lt) begin
         clr(j);
         cyc(2);
         ok(f === 10'h000 && !safe);
      end
   endtask
   // ===
   // main sequence
   initial begin
      seed = 36611;
      err_total = 0;
      checked = 0;
      {sys_rst_i, lat, ldis, sen, shen, don, ovl} = 7'h40;
      {lvp, lvn, c, k} = 22'h090000;
      sen = 1'b1;
      shen = 1'b1;
      fs = 2'h1;
      cyc(3);
      chk({4'h0, pch, nch, safe, fly, dis, src}, 10'h03e);
      sys_rst_i = 1'b0;
      cyc(4);
      ok(f === 10'h000 && !safe && !fly);
      for (i = 0; i < 16; i++) begin
         lat = i[3];
         fault(i % 8, 1'b1);
      end
      lat = 1'b0;
      lvp = 3'h7;
      fault(0, 1'b0);
      lvp = 3'h2;
      lvn = 3'h7;
      fault(1, 1'b0);
      lvn = 3'h2;
      ldis = 1'b1;
      fault(5, 1'b0);
      ldis = 1'b0;
      don = 1'b1;
      upto(0);
      ok(n >= 49 && n <= 53 && !dis);
      ovl = 1'b1;
      // pulse stays well short of the 25 cycle filter
      cyc(14 + ($random(seed) & 7));
      ovl = 1'b0;
      cyc(40);
      ok(!pch && !safe);
      ovl = 1'b1;
      upto(1);
      ok(nch && safe);
      upto(2);
      ok(n >= 18 && n <= 22);
      ovl = 1'b0;
      cyc(30);
      ok(pch && f[8]);
      clr(4);
      cyc(4);
      ok(!pch && !safe && f === 10'h000);
      sen = 1'b0;
      fs = 2'h0;
      upto(0);
      ovl = 1'b1;
      cyc(100);
      ok(!pch && !f[8]);
      ovl = 1'b0;
      c[9] = 1'b1;
      upto(1);
      ok(n >= 10 && n <= 15 && safe);
      upto(3);
      ok(n >= 18 && n <= 22);
      c[9] = 1'b0;
      clr(5);
      cyc(4);
      ok(!pch && f === 10'h000);
      shen = 1'b0;
      c[9] = 1'b1;
      cyc(40);
      ok(!pch && !f[9]);
      final_report;
   end
endmodule // sgprot_top_tb_top
bind sgprot_top sgprot_top_chk i_chk (
   .clk_i(clk_i),
   .sys_rst_i(sys_rst_i),
   .pos_uv_cmp_i(pos_uv_cmp_i),
   .undervolt_latch_select_i(undervolt_latch_select_i),
   .pos_supply_turnon_level_i(pos_supply_turnon_level_i),
   .saturation_protect_enable_i(saturation_protect_enable_i),
   .clr_pos_uv_i(clr_pos_uv_i),
   .clr_pos_ov_i(clr_pos_ov_i),
   .pchannel_predrive_o(pchannel_predrive_o),
   .nchannel_predrive_o(nchannel_predrive_o),
   .protective_off_state_o(protective_off_state_o),
   .saturation_monitor_pin_discharge_o(saturation_monitor_pin_discharge_o),
   .saturation_monitor_pin_source_en_o(saturation_monitor_pin_source_en_o),
   .pos_supply_undervolt_flag_o(pos_supply_undervolt_flag_o),
   .neg_supply_undervolt_flag_o(neg_supply_undervolt_flag_o),
   .pos_supply_overvolt_flag_o(pos_supply_overvolt_flag_o),
   .neg_supply_overvolt_flag_o(neg_supply_overvolt_flag_o),
   .thermal_shutdown_flag_o(thermal_shutdown_flag_o),
   .saturation_fault_flag_o(saturation_fault_flag_o),
   .shunt_overcurrent_flag_o(shunt_overcurrent_flag_o)
);
